// ---- logic/iag_pkg.sv ----
package iag_pkg;
  // Operand field and datapath widths
  localparam int MOD_W = 5;
  localparam int DISP_W = 8;
  localparam int ARITH_W = 24;
  localparam int WORD_W = 32;
  localparam int EXT_W = 26;

  // Group held in the top two bits of the modification field
  localparam logic [1:0] GRP_DISP = 2'h0;
  localparam logic [1:0] GRP_INDEX_ZERO = 2'h1;
  localparam logic [1:0] GRP_INDEX_ONE = 2'h2;
  localparam logic [1:0] GRP_SPECIAL = 2'h3;

  // Special-case codes
  localparam logic [MOD_W-1:0] MOD_PLAIN = 5'h18;
  localparam logic [MOD_W-1:0] MOD_BITREV = 5'h19;

  // Implied displacement when none is coded
  localparam logic [ARITH_W-1:0] DISP_IMPLIED = 24'h000001;

  // Reset values of the result registers
  localparam logic [ARITH_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [WORD_W-1:0] PTR_RST = 32'h00000000;

  // Operation held in bits 2:1 of the modification field
  typedef enum logic [1:0] {
    KIND_PRE = 2'b00,
    KIND_PRE_MOD = 2'b01,
    KIND_POST_MOD = 2'b10,
    KIND_POST_CIRC = 2'b11
  } kind_t;
endpackage

// ---- logic/circ_modify.sv ----
module circ_modify (
  input wire logic [iag_pkg::ARITH_W-1:0] ptr_lo,
  input wire logic [iag_pkg::ARITH_W-1:0] step,
  input wire logic [iag_pkg::ARITH_W-1:0] block_size,
  input wire logic sub,
  output logic [iag_pkg::ARITH_W-1:0] result
);
  import iag_pkg::*;

  logic [ARITH_W-1:0] mask;
  logic [EXT_W-1:0] raw;
  logic [EXT_W-1:0] wrapped;

  // Index mask is 2^K-1, the smallest K with 2^K above the block size
  always_comb begin
    mask[ARITH_W-1] = block_size[ARITH_W-1];
    for (int i = ARITH_W - 2; i >= 0; i--) begin
      mask[i] = mask[i+1] | block_size[i];
    end
  end

  // Step is unsigned; two spare bits catch the borrow of a subtract
  always_comb begin
    if (sub) begin
      raw = {2'h0, ptr_lo & mask} - {2'h0, step};
    end else begin
      raw = {2'h0, ptr_lo & mask} + {2'h0, step};
    end
  end

  // Wrap back into the block in either direction
  always_comb begin
    if (raw[EXT_W-1]) begin
      wrapped = raw + {2'h0, block_size};
    end else if (raw >= {2'h0, block_size}) begin
      wrapped = raw - {2'h0, block_size};
    end else begin
      wrapped = raw;
    end
  end

  // Bits above the index field are left untouched
  assign result = (ptr_lo & ~mask) | (wrapped[ARITH_W-1:0] & mask);
endmodule

// ---- logic/indirect_address_generator.sv ----
module indirect_address_generator (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic [iag_pkg::MOD_W-1:0] mod_field,
  input wire logic disp_present,
  input wire logic [iag_pkg::DISP_W-1:0] disp_field,
  input wire logic [iag_pkg::WORD_W-1:0] pointer_in,
  input wire logic [iag_pkg::WORD_W-1:0] index_reg_zero,
  input wire logic [iag_pkg::WORD_W-1:0] index_reg_one,
  input wire logic [iag_pkg::WORD_W-1:0] block_size_reg,
  output logic result_valid,
  output logic [iag_pkg::ARITH_W-1:0] operand_addr,
  output logic pointer_wr_en,
  output logic [iag_pkg::WORD_W-1:0] pointer_out,
  output logic mod_illegal
);
  import iag_pkg::*;

  logic [1:0] grp;
  kind_t kind;
  logic sub;
  logic [ARITH_W-1:0] ptr_lo;
  logic [ARITH_W-1:0] step;
  logic [ARITH_W-1:0] offs;
  logic [ARITH_W-1:0] circ_lo;
  logic [ARITH_W-1:0] rev_ptr;
  logic [ARITH_W-1:0] rev_step;
  logic [ARITH_W-1:0] rev_sum;
  logic [ARITH_W-1:0] brev_lo;
  logic [ARITH_W-1:0] new_lo;
  logic [ARITH_W-1:0] addr_next;
  logic wr_next;
  logic illegal_next;
  logic valid_reg;
  logic wr_reg;
  logic illegal_reg;
  logic [ARITH_W-1:0] addr_reg;
  logic [WORD_W-1:0] ptr_reg;

  // Field split: group, operation, direction
  assign grp = mod_field[MOD_W-1:MOD_W-2];
  assign kind = kind_t'(mod_field[2:1]);
  assign sub = mod_field[0];
  assign ptr_lo = pointer_in[ARITH_W-1:0];

  // Step source; the special group only ever needs index register zero
  always_comb begin
    unique case (grp)
      GRP_DISP: step = disp_present ? {16'h0000, disp_field} : DISP_IMPLIED;
      GRP_INDEX_ZERO: step = index_reg_zero[ARITH_W-1:0];
      GRP_INDEX_ONE: step = index_reg_one[ARITH_W-1:0];
      GRP_SPECIAL: step = index_reg_zero[ARITH_W-1:0];
    endcase
  end

  // Plain offset wraps modulo 2^24, as unsigned arithmetic does
  assign offs = sub ? ptr_lo - step : ptr_lo + step;

  circ_modify u_circ (
    .ptr_lo(ptr_lo),
    .step(step),
    .block_size(block_size_reg[ARITH_W-1:0]),
    .sub(sub),
    .result(circ_lo)
  );

  // Reverse carry: mirror both operands, add, mirror back; the carry out
  // of the mirrored top is the carry below bit zero and is dropped
  always_comb begin
    for (int i = 0; i < ARITH_W; i++) begin
      rev_ptr[i] = ptr_lo[ARITH_W-1-i];
      rev_step[i] = step[ARITH_W-1-i];
    end
  end
  assign rev_sum = rev_ptr + rev_step;
  always_comb begin
    for (int i = 0; i < ARITH_W; i++) begin
      brev_lo[i] = rev_sum[ARITH_W-1-i];
    end
  end

  // Mode decode: address, pointer update and its value
  always_comb begin
    addr_next = ptr_lo;
    new_lo = ptr_lo;
    wr_next = 1'b0;
    illegal_next = 1'b0;
    if (grp == GRP_SPECIAL) begin
      if (mod_field == MOD_PLAIN) begin
        addr_next = ptr_lo;
      end else if (mod_field == MOD_BITREV) begin
        wr_next = 1'b1;
        new_lo = brev_lo;
      end else begin
        illegal_next = 1'b1;
      end
    end else begin
      unique case (kind)
        KIND_PRE: begin
          addr_next = offs;
        end
        KIND_PRE_MOD: begin
          addr_next = offs;
          wr_next = 1'b1;
          new_lo = offs;
        end
        KIND_POST_MOD: begin
          wr_next = 1'b1;
          new_lo = offs;
        end
        KIND_POST_CIRC: begin
          wr_next = 1'b1;
          new_lo = circ_lo;
        end
      endcase
    end
  end

  // Handshake flags; a strobe only when a request was taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_reg <= 1'b0;
      wr_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      valid_reg <= req_valid;
      wr_reg <= req_valid & wr_next;
      illegal_reg <= req_valid & illegal_next;
    end
  end

  // Result data is held between requests so the fetch can reuse it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_reg <= ADDR_RST;
      ptr_reg <= PTR_RST;
    end else if (req_valid) begin
      addr_reg <= addr_next;
      ptr_reg <= {pointer_in[WORD_W-1:ARITH_W], new_lo};
    end
  end

  assign result_valid = valid_reg;
  assign operand_addr = addr_reg;
  assign pointer_wr_en = wr_reg;
  assign pointer_out = ptr_reg;
  assign mod_illegal = illegal_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_valid_follows_req:
  assert property (result_valid == $past(req_valid))
    else $error("result strobe does not follow request");

  a_idx_one_pre:
  assert property (req_valid && grp == GRP_INDEX_ONE && kind == KIND_PRE |=>
    !pointer_wr_en && operand_addr == ($past(sub) ?
    $past(ptr_lo) - $past(index_reg_one[ARITH_W-1:0]) :
    $past(ptr_lo) + $past(index_reg_one[ARITH_W-1:0])))
    else $error("index one preindex address wrong or pointer written");

  a_pre_mod_store:
  assert property (req_valid && grp != GRP_SPECIAL && kind == KIND_PRE_MOD |=>
    pointer_wr_en && pointer_out[ARITH_W-1:0] == operand_addr)
    else $error("preindex modify did not store the address");

  a_post_addr_raw:
  assert property (req_valid && grp != GRP_SPECIAL && kind[1] |=>
    pointer_wr_en && operand_addr == $past(ptr_lo))
    else $error("post-modify mode did not address the raw pointer");

  a_idx_zero_post:
  assert property (req_valid && grp == GRP_INDEX_ZERO && kind == KIND_POST_MOD && sub |=>
    pointer_out[ARITH_W-1:0] == $past(ptr_lo) - $past(index_reg_zero[ARITH_W-1:0]))
    else $error("index zero postindex subtract result wrong");

  a_plain_no_write:
  assert property (req_valid && mod_field == MOD_PLAIN |=>
    !pointer_wr_en && !mod_illegal && operand_addr == $past(ptr_lo))
    else $error("plain indirect altered pointer or address");

  a_bitrev_write:
  assert property (req_valid && mod_field == MOD_BITREV |=>
    pointer_wr_en && operand_addr == $past(ptr_lo))
    else $error("bit-reversed mode address or write wrong");

  a_implied_disp:
  assert property (req_valid && grp == GRP_DISP && !disp_present && kind == KIND_PRE
    && !sub |=> operand_addr == $past(ptr_lo) + 24'h000001)
    else $error("implied displacement is not one");

  a_upper_kept:
  assert property (req_valid |=>
    pointer_out[WORD_W-1:ARITH_W] == $past(pointer_in[WORD_W-1:ARITH_W]))
    else $error("upper pointer bits changed");

  a_illegal_code:
  assert property (req_valid && grp == GRP_SPECIAL && mod_field != MOD_PLAIN
    && mod_field != MOD_BITREV |=> mod_illegal && !pointer_wr_en)
    else $error("unused special code not flagged");
endmodule

// ---- sim/operand_fetch_model.sv ----
module operand_fetch_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ld_en,
  input wire logic [iag_pkg::WORD_W-1:0] ld_val,
  input wire logic pointer_wr_en,
  input wire logic [iag_pkg::WORD_W-1:0] pointer_out,
  output logic [iag_pkg::WORD_W-1:0] pointer_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import iag_pkg::*;
  // Pointer file entry; the block keeps no copy, so write-back must land here
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pointer_in <= PTR_RST;
    end else if (ld_en) begin
      pointer_in <= ld_val;
    end else if (pointer_wr_en) begin
      pointer_in <= pointer_out;
    end
  end
endmodule

// ---- sim/indirect_address_generator_bench.sv ----
module indirect_address_generator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import iag_pkg::*;
  logic sys_clk = 0, rst_b = 0, req_valid = 0, disp_present = 0, ld_en = 0;
  logic [MOD_W-1:0] mod_field = '0;
  logic [DISP_W-1:0] disp_field = '0;
  logic [WORD_W-1:0] pointer_in, ld_val = '0, pointer_out;
  logic [WORD_W-1:0] index_reg_zero = 32'hFF000003, index_reg_one = 32'h7F000005;
  logic [WORD_W-1:0] block_size_reg = 32'hFF000006;
  logic result_valid, pointer_wr_en, mod_illegal;
  logic [ARITH_W-1:0] operand_addr;
  int err_count = 0, cmp_count = 0;

  indirect_address_generator uut (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
    .mod_field(mod_field), .disp_present(disp_present), .disp_field(disp_field),
    .pointer_in(pointer_in), .index_reg_zero(index_reg_zero), .index_reg_one(index_reg_one),
    .block_size_reg(block_size_reg), .result_valid(result_valid), .operand_addr(operand_addr),
    .pointer_wr_en(pointer_wr_en), .pointer_out(pointer_out), .mod_illegal(mod_illegal));
  operand_fetch_model fetch (.sys_clk(sys_clk), .rst_b(rst_b), .ld_en(ld_en), .ld_val(ld_val),
    .pointer_wr_en(pointer_wr_en), .pointer_out(pointer_out), .pointer_in(pointer_in));

  // 25 MHz clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [23:0] rv(input logic [23:0] x);
    for (int i = 0; i < 24; i++) rv[i] = x[23-i];
  endfunction

  // Reference result built only from the mode table, never from the block
  task automatic calc(input logic [4:0] m, input logic dp, input logic [7:0] d,
      output logic [23:0] ea, output logic [31:0] ep, output logic ew, output logic ei);
    logic [23:0] p, st, s, msk;
    int k, ix;
    p = pointer_in[23:0];
    st = (m[4:3] == GRP_INDEX_ZERO || m == MOD_BITREV) ? index_reg_zero[23:0] :
         (m[4:3] == GRP_INDEX_ONE) ? index_reg_one[23:0] : dp ? {16'h0000, d} : DISP_IMPLIED;
    s = m[0] ? p - st : p + st;
    ea = p;
    ew = (m[4:3] != GRP_SPECIAL && m[2:1] != KIND_PRE) || m == MOD_BITREV;
    ei = m > MOD_BITREV;
    if (m == MOD_BITREV) s = rv(rv(p) + rv(st));
    else if (m[4:3] != GRP_SPECIAL && m[2:1] inside {KIND_PRE, KIND_PRE_MOD}) ea = s;
    else if (m[4:3] != GRP_SPECIAL && m[2:1] == KIND_POST_CIRC) begin
      k = 0;
      for (int i = 0; i < 24; i++) if (block_size_reg[i]) k = i + 1;
      msk = 24'((25'h1 << k) - 1);
      ix = int'(p & msk) + (m[0] ? -int'(st) : int'(st));
      if (ix >= int'(block_size_reg[23:0])) ix -= int'(block_size_reg[23:0]);
      else if (ix < 0) ix += int'(block_size_reg[23:0]);
      s = (block_size_reg[23:0] == 24'h0) ? p : (p & ~msk) | 24'(ix);
    end
    ep = ew ? {pointer_in[31:24], s} : pointer_in;
  endtask

  task automatic load(input logic [31:0] v);
    ld_en = 1;
    ld_val = v;
    @(posedge sys_clk);
    #1 ld_en = 0;
  endtask

  // One request, answer checked in the cycle it stands, then write-back lands
  task automatic req(input logic [4:0] m, input logic dp, input logic [7:0] d);
    logic [23:0] ea;
    logic [31:0] ep;
    logic ew, ei;
    int n;
    calc(m, dp, d, ea, ep, ew, ei);
    {mod_field, disp_present, disp_field, req_valid} = {m, dp, d, 1'b1};
    @(posedge sys_clk);
    #1 req_valid = 0;
    n = 0;
    while (result_valid !== 1'b1 && n < 3) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (result_valid !== 1'b1) begin
      err_count++;
      tally_and_finish;
    end
    chk(32'(n), 32'h0);
    chk({pointer_wr_en, mod_illegal, 6'h00, operand_addr}, {ew, ei, 6'h00, ea});
    chk(pointer_out, ep);
    @(posedge sys_clk);
    #1 chk(32'(result_valid), 32'h0);
  endtask

  task automatic sweep;
    logic [31:0] pv [2] = '{32'hAB000100, 32'hC5000002};
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 32; c++) begin
        load(pv[p]);
        if (c < 16) req(5'(c), p == 0, 8'h04);
        else req(5'(c), p == 0, 8'h04);
      end
    end
  endtask

  task automatic circ_walk;
    logic [4:0] md [5] = '{5'h06, 5'h06, 5'h07, 5'h06, 5'h07};
    logic [7:0] ds [5] = '{8'h05, 8'h02, 8'h03, 8'h06, 8'h00};
    logic [23:0] ex [5] = '{24'h5, 24'h1, 24'h4, 24'h4, 24'h3};
    block_size_reg = 32'h00000006;
    load(32'h00000000);
    for (int i = 0; i < 5; i++) begin
      req(md[i], i < 4, ds[i]);
      chk(pointer_out, {8'h00, ex[i]});
    end
  endtask

  task automatic bitrev_walk;
    index_reg_zero = 32'h00800000;
    load(32'h5A000000);
    req(MOD_BITREV, 1'b0, 8'h00);
    chk(pointer_out, 32'h5A800000);
    req(MOD_BITREV, 1'b0, 8'h00);
    chk(pointer_out, 32'h5A400000);
  endtask

  // Reset in mid-answer must clear every output at once
  task automatic reset_mid;
    load(32'h12345678);
    {mod_field, req_valid} = {MOD_BITREV, 1'b1};
    @(posedge sys_clk);
    #1 req_valid = 0;
    rst_b = 0;
    #1 chk({5'h0, result_valid, pointer_wr_en, mod_illegal, operand_addr}, 32'h0);
    chk(pointer_out, PTR_RST);
    @(posedge sys_clk);
    #1 rst_b = 1;
    // First request right after release must be served normally
    req(5'h02, 1'b1, 8'h04);
    chk(pointer_out, 32'h00000004);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst_b = 1;
    @(posedge sys_clk);
    #1 sweep;
    circ_walk;
    bitrev_walk;
    reset_mid;
    tally_and_finish;
  end
endmodule
